// ===== design/pog_pkg.sv
// Shared constants and types of the PWM output generator.
// Assumes one clock (mclk) that stands for the fixed timer base.
package pog_pkg;

  // Register byte offsets on the AHB-Lite slave
  localparam logic [7:0]  OFS_CTRL    = 8'h00;
  localparam logic [7:0]  OFS_PERIOD  = 8'h04;
  localparam logic [7:0]  OFS_DUTY    = 8'h08;
  localparam logic [7:0]  OFS_STAT    = 8'h0C;

  // Control word values and reset values
  localparam logic [15:0] RST_CTRL    = 16'h0000;
  localparam logic [15:0] CTRL_ON     = 16'h0001;
  localparam logic [7:0]  RST_PERIOD  = 8'h3F;
  localparam logic [1:0]  RST_PRE     = 2'h0;
  localparam logic [7:0]  RST_DUTY_HI = 8'h20;
  localparam logic [1:0]  RST_DUTY_LO = 2'h0;

  // Field positions in the period and duty registers
  localparam int HI_MSB = 15;
  localparam int HI_LSB = 8;
  localparam int LO_MSB = 1;
  localparam int LO_LSB = 0;

  // Field positions in the status register
  localparam int STAT_DUTY_LSB = 16;
  localparam int STAT_RUN_BIT  = 30;
  localparam int STAT_PIN_BIT  = 31;

  // Prescaler codes and their divide factors
  localparam logic [1:0]  PRE_DIV1    = 2'h0;
  localparam logic [1:0]  PRE_DIV4    = 2'h1;
  localparam logic [1:0]  PRE_DIV16   = 2'h2;
  localparam int          DIV1        = 1;
  localparam int          DIV4        = 4;
  localparam int          DIV16       = 16;

  // Timer base and clock rate, and base period in clock cycles
  localparam longint      TIMER_HZ    = 32000000;
  localparam longint      OSC_HZ      = 8000000;
  localparam int          TBASE_PS    = 31250;
  localparam int          MCLK_PS     = 100000;
  localparam int          BASE_CYC    = (TBASE_PS / MCLK_PS < 1) ? 1
                                        : TBASE_PS / MCLK_PS;

  // Timer step in duty units and low bits of the wrap count
  localparam logic [9:0]  STEP        = 10'h002;
  localparam logic [1:0]  WRAP_LO     = 2'h2;

  // AHB response code
  localparam logic        HRESP_OKAY  = 1'b0;

  // Output on/off state
  typedef enum logic {ST_OFF, ST_RUN} pog_state_e;

  // Latched address phase
  typedef struct packed {
    logic       valid;
    logic       write;
    logic [7:0] addr;
  } pog_aph_s;

  // Period and prescaler setting
  typedef struct packed {
    logic [7:0] period;
    logic [1:0] pre;
  } pog_cfg_s;

  // Ten-bit duty value in its two parts
  typedef struct packed {
    logic [7:0] hi;
    logic [1:0] lo;
  } pog_duty_s;

endpackage

// ===== design/pog_prescale.sv
// Prescaler: one tick every 1, 4 or 16 base timer periods.
// Assumes run drops whenever the output is off.
module pog_prescale
  import pog_pkg::*;
#(
  parameter int CNT_W = 5
)
(
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rst,
  // Control
  input  wire logic       run,
  input  wire logic [1:0] pre,
  // Prescaled tick
  output logic            tick
);

  logic [CNT_W-1:0] cnt_r;    // Base periods counted so far
  logic [CNT_W-1:0] cnt_nxt;  // Next count
  logic [CNT_W-1:0] last;     // Final count of one tick

  // Decode the divide factor
  always_comb
  begin
    unique case (pre)
      PRE_DIV4:  last = CNT_W'(DIV4 * BASE_CYC - 1);
      PRE_DIV16: last = CNT_W'(DIV16 * BASE_CYC - 1);
      // Divide by one, also taken for the unused code
      default:   last = CNT_W'(DIV1 * BASE_CYC - 1);
    endcase
  end

  // Count, restart when stopped or at the tick
  always_comb
  begin
    if (!run || cnt_r >= last)
      cnt_nxt = '0;
    else
      cnt_nxt = cnt_r + 1'b1;
  end

  // A tick also ends a count cut short by a smaller factor
  assign tick = run && (cnt_r >= last);

  // Register the count
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      cnt_r <= '0;
    else
      cnt_r <= cnt_nxt;
  end

endmodule // pog_prescale

// ===== design/pog_duty_buf.sv
// Active duty compare, loaded from the software value on period end.
// Assumes load pulses only at the start of a period.
module pog_duty_buf
  import pog_pkg::*;
(
  // Clock and reset
  input  wire logic      mclk,
  input  wire logic      rst,
  // Load request and software value
  input  wire logic      load,
  input  pog_duty_s      sw_duty,
  // Active duty
  output pog_duty_s      act_duty
);

  logic [7:0] hi_r;    // Upper eight bits in use
  logic [7:0] hi_nxt;  // Next upper bits
  logic [1:0] lo_r;    // Separate two-bit latch
  logic [1:0] lo_nxt;  // Next low bits

  // Take the new value only on load
  always_comb
  begin
    hi_nxt = load ? sw_duty.hi : hi_r;
    lo_nxt = load ? sw_duty.lo : lo_r;
  end

  // Register both parts
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      hi_r <= RST_DUTY_HI;
      lo_r <= RST_DUTY_LO;
    end
    else
    begin
      hi_r <= hi_nxt;
      lo_r <= lo_nxt;
    end
  end

  assign act_duty = '{hi: hi_r, lo: lo_r};

endmodule // pog_duty_buf

// ===== design/pog_top.sv
// PWM output generator: AHB-Lite register slave and modulation timer.
// Assumes mclk is the timer base and a single AHB-Lite master.
module pog_top
  import pog_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Modulated output pin
  output logic             pwm_out
);

  // Bus state
  pog_aph_s    aph_r;          // Address phase of the pending transfer
  pog_aph_s    aph_nxt;        // Next address phase
  logic        ap_take;        // Transfer taken this cycle
  logic        wr_dp;          // Write data phase this cycle
  logic [31:0] rdata_r;        // Read data for the data phase
  logic [31:0] rdata_nxt;      // Next read data
  logic        hreadyout_r;    // Ready to the master
  logic        hresp_r;        // Response to the master

  // Software registers
  logic [15:0] ctrl_r;         // Control word
  logic [15:0] ctrl_nxt;       // Next control word
  pog_cfg_s    cfg_r;          // Period and prescaler
  pog_cfg_s    cfg_nxt;        // Next period and prescaler
  pog_duty_s   dreg_r;         // Duty value as written
  pog_duty_s   dreg_nxt;       // Next duty value

  // Timer state
  pog_state_e  st_r;           // Output on or off
  pog_state_e  st_nxt;         // Next on/off state
  logic [9:0]  cnt_r;          // Timer in duty units
  logic [9:0]  cnt_nxt;        // Next timer value
  logic        pin_r;          // Output pin level
  logic        pin_nxt;        // Next pin level
  logic        on;             // Control word asks for output
  logic        run;            // Timer may advance
  logic        tick;           // Prescaled base tick
  logic        load;           // Move duty into the compare
  logic [9:0]  wrap;           // Last timer value of a period
  logic [9:0]  step_cnt;       // Timer after one step
  pog_duty_s   act_duty;       // Duty in the active compare

  // Ports straight from flip-flops
  assign hreadyout = hreadyout_r;
  assign hresp     = hresp_r;
  assign hrdata    = rdata_r;
  assign pwm_out   = pin_r;

  // Bus: address phase is taken on a NONSEQ or SEQ with hready
  assign ap_take = hsel && hready && htrans[1];
  assign wr_dp   = aph_r.valid && aph_r.write;

  // Address phase capture; only whole words are expected, hsize unused
  always_comb
  begin
    aph_nxt = aph_r;
    if (hready)
    begin
      aph_nxt.valid = ap_take;
      aph_nxt.write = hwrite;
      aph_nxt.addr  = haddr;
    end
  end

  // Register writes in the data phase
  always_comb
  begin
    ctrl_nxt = ctrl_r;
    cfg_nxt  = cfg_r;
    dreg_nxt = dreg_r;
    if (wr_dp)
    begin
      unique case (aph_r.addr)
        // Full control word is kept
        OFS_CTRL:
        begin
          ctrl_nxt = hwdata[15:0];
        end
        // Bits 7-2 are dropped
        OFS_PERIOD:
        begin
          cfg_nxt.period = hwdata[HI_MSB:HI_LSB];
          cfg_nxt.pre    = hwdata[LO_MSB:LO_LSB];
        end
        // Accepted at any time, used at period end
        OFS_DUTY:
        begin
          dreg_nxt.hi = hwdata[HI_MSB:HI_LSB];
          dreg_nxt.lo = hwdata[LO_MSB:LO_LSB];
        end
        // Status and unmapped addresses ignore writes
        default:
        begin
        end
      endcase
    end
  end

  // Read data from next values, except the active duty, so a read right after a write is fresh
  always_comb
  begin
    rdata_nxt = 32'h0000_0000;
    if (ap_take && !hwrite)
    begin
      unique case (haddr)
        // Control word
        OFS_CTRL:
        begin
          rdata_nxt[15:0] = ctrl_nxt;
        end
        // Period and prescaler, bits 7-2 zero
        OFS_PERIOD:
        begin
          rdata_nxt[HI_MSB:HI_LSB] = cfg_nxt.period;
          rdata_nxt[LO_MSB:LO_LSB] = cfg_nxt.pre;
        end
        // Software duty value, bits 7-2 zero
        OFS_DUTY:
        begin
          rdata_nxt[HI_MSB:HI_LSB] = dreg_nxt.hi;
          rdata_nxt[LO_MSB:LO_LSB] = dreg_nxt.lo;
        end
        // Timer, active duty, running flag, pin
        OFS_STAT:
        begin
          rdata_nxt[9:0] = cnt_nxt;
          rdata_nxt[STAT_DUTY_LSB+:10] = act_duty;
          rdata_nxt[STAT_RUN_BIT] = (st_nxt == ST_RUN);
          rdata_nxt[STAT_PIN_BIT] = pin_nxt;
        end
        // Unmapped addresses read zero
        default:
        begin
        end
      endcase
    end
  end

  // Bus and software registers
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      aph_r       <= '0;
      rdata_r     <= 32'h0000_0000;
      hreadyout_r <= 1'b1;
      hresp_r     <= HRESP_OKAY;
      ctrl_r      <= RST_CTRL;
      cfg_r       <= '{period: RST_PERIOD, pre: RST_PRE};
      dreg_r      <= '{hi: RST_DUTY_HI, lo: RST_DUTY_LO};
    end
    else
    begin
      aph_r       <= aph_nxt;
      rdata_r     <= rdata_nxt;
      hreadyout_r <= 1'b1;
      hresp_r     <= HRESP_OKAY;
      ctrl_r      <= ctrl_nxt;
      cfg_r       <= cfg_nxt;
      dreg_r      <= dreg_nxt;
    end
  end

  // Only the exact on value runs the output; anything else is off
  assign on  = (ctrl_r == CTRL_ON);
  assign run = on && (st_r == ST_RUN);

  // Wrap at 4*period+2 so a period is 2*(period+1) ticks
  assign wrap     = {cfg_r.period, WRAP_LO};
  assign step_cnt = cnt_r + STEP;

  // One tick per base period times the prescale factor
  pog_prescale #(
    .CNT_W (5)
  ) u_prescale (
    .mclk (mclk),
    .rst  (rst),
    .run  (run),
    .pre  (cfg_r.pre),
    .tick (tick)
  );

  // Double buffer of the duty compare
  pog_duty_buf u_duty_buf (
    .mclk     (mclk),
    .rst      (rst),
    .load     (load),
    .sw_duty  (dreg_r),
    .act_duty (act_duty)
  );

  // On/off state and timer
  always_comb
  begin
    st_nxt  = st_r;
    cnt_nxt = cnt_r;
    pin_nxt = pin_r;
    load    = 1'b0;
    unique case (st_r)
      // Off: pin low, timer held at zero
      ST_OFF:
      begin
        cnt_nxt = '0;
        pin_nxt = 1'b0;
        if (on)
        begin
          // Fresh period with the current duty
          st_nxt  = ST_RUN;
          load    = 1'b1;
          pin_nxt = (dreg_r != '0);
        end
      end
      // Running
      ST_RUN:
      begin
        if (!on)
        begin
          st_nxt  = ST_OFF;
          cnt_nxt = '0;
          pin_nxt = 1'b0;
        end
        else if (tick)
        begin
          if (cnt_r >= wrap)
          begin
            // Period end: clear timer, take new duty, set pin unless the new duty is zero
            cnt_nxt = '0;
            load    = 1'b1;
            pin_nxt = (dreg_r != '0);
          end
          else
          begin
            // High while timer is below duty; never cleared if longer
            cnt_nxt = step_cnt;
            pin_nxt = (step_cnt < act_duty);
          end
        end
      end
    endcase
  end

  // Register the timer state
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      st_r  <= ST_OFF;
      cnt_r <= '0;
      pin_r <= 1'b0;
    end
    else
    begin
      st_r  <= st_nxt;
      cnt_r <= cnt_nxt;
      pin_r <= pin_nxt;
    end
  end

endmodule // pog_top

// ===== testbench/pog_monitor.sv
// Port-level checker of the PWM output generator.
// Assumes hready is tied to hreadyout and one bus master.
module pog_monitor
  import pog_pkg::*;
(
  // Clock and reset
  input logic        mclk,
  input logic        rst,
  // AHB-Lite slave
  input logic        hsel,
  input logic [7:0]  haddr,
  input logic [1:0]  htrans,
  input logic        hwrite,
  input logic [31:0] hwdata,
  input logic        hready,
  input logic        hreadyout,
  input logic        hresp,
  input logic [31:0] hrdata,
  // Output pin
  input logic        pwm_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  pog_aph_s    aph_r, aph_nxt;   // Address phase seen last edge
  logic [15:0] ctl_r, ctl_nxt;   // Shadow control word
  pog_cfg_s    cfg_r, cfg_nxt;   // Shadow period setting
  logic [9:0]  dut_r, dut_nxt;   // Shadow duty value
  int quiet_r, quiet_nxt;        // Cycles since last write
  int hi_r, hi_nxt, lo_r, lo_nxt; // High and low run lengths
  int f, per, exh;               // Factor, period, high time
  logic wr, on, calm;            // Write, running, settled
  // Shadow registers and run counters, next values
  always_comb
  begin
    aph_nxt = '{hsel & hready & htrans[1], hwrite, haddr};
    wr = aph_r.valid & aph_r.write;
    ctl_nxt = (wr && aph_r.addr == OFS_CTRL) ? hwdata[15:0] : ctl_r;
    cfg_nxt = (wr && aph_r.addr == OFS_PERIOD) ?
              '{hwdata[15:8], hwdata[1:0]} : cfg_r;
    dut_nxt = (wr && aph_r.addr == OFS_DUTY) ?
              {hwdata[15:8], hwdata[1:0]} : dut_r;
    quiet_nxt = wr ? 0 : quiet_r + 1;
    hi_nxt = pwm_out ? hi_r + 1 : 0;
    lo_nxt = pwm_out ? 0 : lo_r + 1;
    f = (cfg_r.pre == PRE_DIV4) ? DIV4 :
        (cfg_r.pre == PRE_DIV16) ? DIV16 : DIV1;
    per = 2 * (cfg_r.period + 1) * f;
    exh = ((dut_r + 1) / 2) * f;
    on = (ctl_r == CTRL_ON);
    calm = on && (quiet_r > 2 * per);
  end
  // Register the helper state
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      aph_r <= '0;
      ctl_r <= RST_CTRL;
      cfg_r <= '{RST_PERIOD, RST_PRE};
      dut_r <= {RST_DUTY_HI, RST_DUTY_LO};
      quiet_r <= 0;
      hi_r <= 0;
      lo_r <= 0;
    end
    else
    begin
      aph_r <= aph_nxt;
      ctl_r <= ctl_nxt;
      cfg_r <= cfg_nxt;
      dut_r <= dut_nxt;
      quiet_r <= quiet_nxt;
      hi_r <= hi_nxt;
      lo_r <= lo_nxt;
    end
  end
  property p_okay;
    hresp == HRESP_OKAY && hreadyout;
  endproperty
  a_okay: assert property (p_okay) else $error("bad response");
  property p_idle;
    !(aph_r.valid && !aph_r.write) |-> hrdata == 32'h0;
  endproperty
  a_idle: assert property (p_idle) else $error("read data not idle");
  property p_resv;
    aph_r.valid && !aph_r.write &&
    (aph_r.addr == OFS_PERIOD || aph_r.addr == OFS_DUTY)
    |-> {hrdata[31:16], hrdata[7:2]} == 22'h0;
  endproperty
  a_resv: assert property (p_resv) else $error("reserved bits set");
  property p_off;
    (ctl_r != CTRL_ON) [*3] |-> !pwm_out;
  endproperty
  a_off: assert property (p_off) else $error("pin high while off");
  property p_zero;
    calm && dut_r == 10'h000 |-> !pwm_out;
  endproperty
  a_zero: assert property (p_zero) else $error("pin high at zero");
  property p_full;
    calm && dut_r > 4 * cfg_r.period + 2 |-> pwm_out;
  endproperty
  a_full: assert property (p_full) else $error("pin cleared");
  property p_high;
    calm && $fell(pwm_out) |-> hi_r == exh;
  endproperty
  a_high: assert property (p_high) else $error("high time");
  property p_low;
    calm && $rose(pwm_out) |-> lo_r == per - exh;
  endproperty
  a_low: assert property (p_low) else $error("low time");
endmodule // pog_monitor

// ===== testbench/pog_load.sv
// Load on the pin: measures high time and period in cycles.
// Assumes the pin is a plain push-pull output.
module pog_load
(
  // Clock and pin
  input  logic        mclk,
  input  logic        pwm_out,
  // Last measured lengths
  output logic [15:0] hi_len,
  output logic [15:0] per_len
);
  timeunit 1ns;
  timeprecision 1ns;
  logic        prev = 1'b0;   // Pin at previous edge
  logic [15:0] lc = 16'h0000; // Cycles since rise
  logic [15:0] hc = 16'h0000; // High cycles so far
  // Rise ends a period, fall ends a high time
  always @(posedge mclk)
  begin
    if (pwm_out && !prev)
    begin
      per_len <= lc;
      lc <= 16'h0001;
      hc <= 16'h0001;
    end
    else
    begin
      lc <= lc + 16'h0001;
      hc <= pwm_out ? hc + 16'h0001 : hc;
    end
    if (!pwm_out && prev)
      hi_len <= hc;
    prev <= pwm_out;
  end
endmodule // pog_load

// ===== testbench/pog_top_tb.sv
// Testbench of the PWM output generator.
// Drives the AHB-Lite slave and watches the pin through a load.
module pog_top_tb
  import pog_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        mclk, rst, hsel, hwrite;  // Clock, reset, bus
  logic [7:0]  haddr;                    // Byte address
  logic [1:0]  htrans;                   // Transfer type
  logic [2:0]  hsize;                    // Word size, tied
  logic [31:0] hwdata, hrdata;           // Bus data
  logic        hreadyout, hresp, pwm_out; // Slave outputs
  logic [15:0] hi_len, per_len;          // Load measurements
  int          num_errors, n_checks;     // Result counters
  pog_top dut (.mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .pwm_out(pwm_out));
  pog_load u_load (.mclk(mclk), .pwm_out(pwm_out), .hi_len(hi_len),
    .per_len(per_len));
  // Compare and count
  task chk(input string nm, input logic [31:0] got, exp);
    n_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch %s exp %h got %h", nm, exp, got);
    end
  endtask
  // One single AHB-Lite transfer
  task bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
           output logic [31:0] rd);
    @(posedge mclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    rd = hrdata;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask
  task rc(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    chk(nm, x, e);
  endtask
  // Duty register image of a ten-bit value
  function automatic logic [31:0] dreg(input logic [9:0] d);
    return {16'h0000, d[9:2], 6'h00, d[1:0]};
  endfunction
  // Reset values and unmapped place
  task t_reset;
    chk("pin", pwm_out, 32'h0);
    rc("ctrl", OFS_CTRL, {16'h0000, RST_CTRL});
    rc("period", OFS_PERIOD, {RST_PERIOD, 6'h00, RST_PRE});
    rc("duty", OFS_DUTY, {RST_DUTY_HI, 6'h00, RST_DUTY_LO});
    wr(8'h10, 32'h0000FFFF);
    rc("unmapped", 8'h10, 32'h0);
    wr(OFS_PERIOD, 32'h0000FFFF);
    rc("period", OFS_PERIOD, 32'h0000FF03);
    wr(OFS_DUTY, 32'h0000FFFF);
    rc("duty", OFS_DUTY, 32'h0000FF03);
    $display("test reset done");
  endtask
  // Every prescale code with a short period
  task t_wave;
    int f[4];
    f = '{1, 4, 16, 1};
    for (int i = 0; i < 4; i++)
    begin
      wr(OFS_PERIOD, 32'h00000100 | i);
      wr(OFS_DUTY, dreg(10'h005));
      wr(OFS_CTRL, 32'h1);
      repeat (12 * f[i] + 8) @(posedge mclk);
      chk("period", per_len, 4 * f[i]);
      chk("high", hi_len, 3 * f[i]);
      wr(OFS_CTRL, 32'h0);
    end
    $display("test wave done");
  endtask
  // Zero duty and duty beyond the period
  task t_edge;
    int seen;
    wr(OFS_PERIOD, 32'h00000100);
    for (int i = 0; i < 2; i++)
    begin
      wr(OFS_DUTY, (i == 1) ? dreg(10'h3FF) : dreg(10'h000));
      wr(OFS_CTRL, 32'h1);
      seen = 0;
      repeat (10) @(posedge mclk);
      repeat (20)
      begin
        @(posedge mclk);
        if (pwm_out !== (i == 1))
          seen++;
      end
      chk("pin", seen, 32'h0);
      wr(OFS_CTRL, 32'h0);
    end
    $display("test edge done");
  endtask
  // Duty taken at period end, then turned off
  task t_buf;
    logic [31:0] s;
    wr(OFS_PERIOD, 32'h0000FF00);
    wr(OFS_DUTY, dreg(10'h101));
    wr(OFS_CTRL, 32'h1);
    wr(OFS_DUTY, dreg(10'h002));
    bus(1'b0, OFS_STAT, 32'h0, s);
    chk("act duty", s[25:16], 32'h101);
    chk("run", s[30], 32'h1);
    repeat (520) @(posedge mclk);
    bus(1'b0, OFS_STAT, 32'h0, s);
    chk("act duty", s[25:16], 32'h002);
    chk("high", hi_len, 32'h1);
    wr(OFS_DUTY, dreg(10'h3FF));
    repeat (520) @(posedge mclk);
    chk("pin", pwm_out, 32'h1);
    wr(OFS_CTRL, 32'h2);
    repeat (3) @(posedge mclk);
    chk("pin", pwm_out, 32'h0);
    bus(1'b0, OFS_STAT, 32'h0, s);
    chk("timer", s[9:0], 32'h0);
    chk("run", s[30], 32'h0);
    $display("test buffer done");
  endtask
  // Verdict and end of run
  task wrap_up;
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Clock
  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  // Watchdog
  initial
  begin
    repeat (20000) @(posedge mclk);
    num_errors++;
    wrap_up();
  end
  // Main sequence
  initial
  begin
    rst    <= 1'b1;
    hsel   <= 1'b0;
    hwrite <= 1'b0;
    haddr  <= 8'h00;
    htrans <= 2'h0;
    hwdata <= 32'h0000_0000;
    hsize  <= 3'h2;
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    t_reset();
    t_wave();
    t_edge();
    t_buf();
    wrap_up();
  end
endmodule // pog_top_tb
bind pog_top pog_monitor u_mon (.mclk(mclk), .rst(rst), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .hrdata(hrdata), .pwm_out(pwm_out));
